// ===== drive_state_regs.svh
// Constants for the drive state command decoder: offsets, fields, reset values.
// Assumes inclusion by the modules that decode or write the command word.
`ifndef DRIVE_STATE_REGS_SVH
`define DRIVE_STATE_REGS_SVH

// Parameter addresses of the register port
`define CMD_WORD_ADDR      16'h1b02
`define STATE_WORD_ADDR    16'h1b01
`define OPMODE_ADDR        16'h1b03
`define CMD_WORD_RESET     16'h0000
`define OPMODE_RESET       8'h00

// Command word fields
`define CMD_SWITCH_ON      0
`define CMD_ENABLE_VOLT    1
`define CMD_QUICK_STOP     2
`define CMD_ENABLE_OP      3
`define CMD_MODE_LO        4
`define CMD_MODE_HI        6
`define CMD_FAULT_RESET    7
`define CMD_HALT           8
`define CMD_RSVD_MASK      16'hfe00

// State word fields
`define STW_VOLTAGE        4
`define STW_HALT           8
`define STW_REMOTE         9
`define STW_TARGET         10
`define STW_ERR            13
`define STW_END            14

`endif

// ===== drive_state_pkg.sv
// Types shared by the drive state command decoder modules.
// Assumes the constants header is compiled alongside.
package drive_state_pkg;

	// Operating states of the power stage, numbered 2 to 9
	typedef enum logic [3:0] {
		ST_NOT_READY,
		ST_SW_ON_DISABLED,
		ST_READY,
		ST_SWITCHED_ON,
		ST_OP_ENABLED,
		ST_QUICK_STOP,
		ST_FAULT_REACTION,
		ST_FAULT
	} drive_state_t;

	// Decoded request from either control source
	typedef enum logic [2:0] {
		REQ_NONE,
		REQ_SHUTDOWN,
		REQ_SWITCH_ON,
		REQ_ENABLE_OP,
		REQ_DISABLE_VOLT,
		REQ_QUICK_STOP,
		REQ_FAULT_RESET
	} drive_req_t;

endpackage : drive_state_pkg

// ===== edge_sync.sv
// Two-flop synchroniser with a rising and falling edge pulse.
// Assumes the input is asynchronous to CLK_I.
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pin and results
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic last_q, last_d;

	// Next values; only sync_q reads the first flop
	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	// Edges compare two settled flops
	assign level_o = sync_q;
	assign rise_o  = sync_q & ~last_q;
	assign fall_o  = ~sync_q & last_q;

endmodule : edge_sync

`default_nettype wire

// ===== cmd_word_decode.sv
// Decodes the fieldbus command word into one state request.
// Assumes the command word comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "drive_state_regs.svh"

module cmd_word_decode
	import drive_state_pkg::*;
(
	// Command input
	input  wire logic [15:0] cmd_i,
	input  wire logic        fault_rise_i,
	// Decoded request
	output drive_req_t       req_o
);

	logic [3:0] low_bits;

	// Only bits 3..0 and the fault-clear edge steer the state machine
	always_comb begin
		low_bits = cmd_i[3:0];                                          // R04
		req_o    = REQ_NONE;
		if (fault_rise_i)
			req_o = REQ_FAULT_RESET;                                    // R10
		else if (!low_bits[`CMD_ENABLE_VOLT])
			req_o = REQ_DISABLE_VOLT;                                   // R09
		else if (!low_bits[`CMD_QUICK_STOP])
			req_o = REQ_QUICK_STOP;                                     // R10
		else if (!low_bits[`CMD_SWITCH_ON])
			req_o = REQ_SHUTDOWN;                                       // R10
		else if (low_bits[`CMD_ENABLE_OP])
			req_o = REQ_ENABLE_OP;                                      // R06
		else
			req_o = REQ_SWITCH_ON;                                      // R05
	end

endmodule : cmd_word_decode

`default_nettype wire

// ===== drive_state_command_decoder.sv
// Power-stage state machine with local and fieldbus command decoding.
// Assumes a 100 MHz CLK_I, pins from outside the clock domain, and
// a simple parameter write/read port on the same clock.
// Reserved command bits are stored for readback only and never decoded;
// the master is expected to keep them at zero.
//
// Contract
// R01 - Local mode ignores the fieldbus command word; status word bit 8 still shows its bit 8 while a mode runs
// R02 - Enable edges step to state 6 or 4
// R03 - Fault-clear edge leaves fault, then re-enables
// R04 - Fieldbus transitions use bits 0-3 and 7
// R05 - Bit 0 switch on, bit 1 voltage
// R06 - Bit 2 quick stop, bit 3 enable
// R07 - Bit 7 fault clear, bit 8 halt
// R08 - Master writes zero to bits 9-15
// R09 - Bit 1 low enters state 3
// R10 - Bits 3..0 patterns select target states
// R11 - Bits 4-6 go to the active mode
// R12 - Bit 8 set requests a halt
// R13 - Written values act at once
// R14 - Mode starts only when ready and initialised
// R15 - Only one operating mode runs
// R16 - Mode change only after completion or discontinuation
// R17 - Standstill marks the mode complete
// R18 - After fault cleared, resume or change mode
// R19 - State word bits show states 2 to 9
// R20 - Mode enabled only in state 6
// R21 - Registered state, one transition, fixed priority
`timescale 1ns/1ps
`default_nettype none
`include "drive_state_regs.svh"

module drive_state_command_decoder
	import drive_state_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// Control source and discrete pins
	input  wire logic        FIELDBUS_MODE_I,
	input  wire logic        ENABLE_PIN_I,
	input  wire logic        FAULT_CLEAR_PIN_I,
	// Drive conditions
	input  wire logic        INIT_DONE_I,
	input  wire logic        VOLTAGE_OK_I,
	input  wire logic        FAULT_I,
	input  wire logic        FAULT_REACTION_DONE_I,
	input  wire logic        STANDSTILL_I,
	input  wire logic        TARGET_REACHED_I,
	// Parameter port
	input  wire logic        PAR_WR_I,
	input  wire logic [15:0] PAR_ADDR_I,
	input  wire logic [15:0] PAR_WDATA_I,
	output logic      [15:0] PAR_RDATA_O,
	// Mode and state outputs
	output logic      [7:0]  ACTIVE_MODE_O,
	output logic             MODE_RUN_O,
	output logic      [2:0]  MODE_BITS_O,
	output logic             HALT_O,
	output logic             POWER_ON_O,
	output logic      [15:0] DRIVE_STATE_WORD_O
);

	// Registered state and parameters
	drive_state_t state_q, state_d;
	logic [15:0]  cmd_q, cmd_d;
	logic [7:0]   opsel_q, opsel_d;
	logic [7:0]   mode_q, mode_d;
	logic         run_q, run_d;
	logic         resume_q, resume_d;
	logic         fc_bit_q, fc_bit_d;
	logic [15:0]  word_q, word_d;
	logic [15:0]  rdata_q, rdata_d;

	// Synchronised pin events and combinational links
	logic       en_level, en_rise, en_fall;
	logic       fc_rise_pin;
	drive_req_t bus_req;
	drive_req_t req;
	logic       bus_fc_rise;
	logic       mode_idle;

	// Discrete pins are synchronised before any logic sees them
	// Synchronisers reset to the idle low level, so reset makes no false edge
	edge_sync u_enable_sync (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.pin_i   (ENABLE_PIN_I),
		.level_o (en_level),
		.rise_o  (en_rise),
		.fall_o  (en_fall)
	);

	edge_sync u_fault_clear_sync (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.pin_i   (FAULT_CLEAR_PIN_I),
		.level_o (),
		.rise_o  (fc_rise_pin),
		.fall_o  ()
	);

	// Fault-clear edge from the command word's bit 7
	// Taken against the stored bit, so rewriting a set bit 7 is no new edge
	assign bus_fc_rise = cmd_q[`CMD_FAULT_RESET] & ~fc_bit_q;              // R07

	// The decoder sees only the stored word, never the raw write data
	cmd_word_decode u_cmd_decode (
		.cmd_i        (cmd_q),
		.fault_rise_i (bus_fc_rise),
		.req_o        (bus_req)
	);

	// Select request source; local mode never looks at the command word
	// Pin edges are one-cycle requests; the enable level carries the rest
	always_comb begin
		req = REQ_NONE;
		if (FIELDBUS_MODE_I) begin
			req = bus_req;                                               // R04
		end else begin                                                   // R01
			if (fc_rise_pin)
				req = REQ_FAULT_RESET;                                   // R03
			else if (en_rise)
				req = REQ_ENABLE_OP;                                     // R02
			else if (en_fall)
				req = REQ_SHUTDOWN;                                      // R02
		end
	end

	// Parameter writes land immediately; reserved bits are stored as written
	// Read data is registered, so it answers the address of the cycle before
	always_comb begin
		cmd_d    = cmd_q;
		opsel_d  = opsel_q;
		fc_bit_d = cmd_q[`CMD_FAULT_RESET];
		if (PAR_WR_I && PAR_ADDR_I == `CMD_WORD_ADDR)
			cmd_d = PAR_WDATA_I;                                         // R13
		if (PAR_WR_I && PAR_ADDR_I == `OPMODE_ADDR)
			opsel_d = PAR_WDATA_I[7:0];                                  // R13
		rdata_d = 16'h0000;
		case (PAR_ADDR_I)
			`CMD_WORD_ADDR:   rdata_d = cmd_q;
			`STATE_WORD_ADDR: rdata_d = word_q;
			`OPMODE_ADDR:     rdata_d = {{8{opsel_q[7]}}, opsel_q};
			default:          rdata_d = 16'h0000;
		endcase
	end

	// State machine: fault first, then voltage, quick stop, others
	always_comb begin
		state_d = state_q;
		case (state_q)
			// State 2 waits for the unit to finish initialising
			ST_NOT_READY:
				if (INIT_DONE_I)
					state_d = ST_SW_ON_DISABLED;
			// Fault reaction ends only when the drive reports it done
			ST_FAULT_REACTION:
				if (FAULT_REACTION_DONE_I)
					state_d = ST_FAULT;
			ST_FAULT: begin
				if (req == REQ_FAULT_RESET && !FAULT_I) begin
					// Fieldbus goes to state 3; local path lands in 4 then 6
					if (FIELDBUS_MODE_I)
						state_d = ST_SW_ON_DISABLED;                     // R10
					else
						state_d = ST_READY;                              // R03
				end
			end
			default: begin
				// Fault outranks every command, then voltage, then quick stop
				if (FAULT_I)
					state_d = ST_FAULT_REACTION;                         // R21
				else if (req == REQ_DISABLE_VOLT && state_q != ST_SW_ON_DISABLED)
					state_d = ST_SW_ON_DISABLED;                         // R09
				else if (req == REQ_QUICK_STOP) begin
					if (state_q == ST_OP_ENABLED)
						state_d = ST_QUICK_STOP;                         // R10
					// Quick stop ends in state 3 at rest, even while bit 2 stays low
					else if (state_q != ST_QUICK_STOP || STANDSTILL_I)
						state_d = ST_SW_ON_DISABLED;                     // R10
				end else if (state_q == ST_QUICK_STOP) begin
					if (STANDSTILL_I)
						state_d = ST_SW_ON_DISABLED;
				end else begin
					case (state_q)
						// Leaving state 3 needs a healthy DC bus
						ST_SW_ON_DISABLED:
							if (VOLTAGE_OK_I && (req == REQ_SHUTDOWN ||
								(!FIELDBUS_MODE_I && en_level)))
								state_d = ST_READY;                      // R10
						// Local enable level walks on through 5 to 6, one step a cycle
						ST_READY:
							if (req == REQ_SWITCH_ON || req == REQ_ENABLE_OP ||
								(!FIELDBUS_MODE_I && en_level))
								state_d = ST_SWITCHED_ON;                // R02
						ST_SWITCHED_ON:
							if (req == REQ_SHUTDOWN)
								state_d = ST_READY;
							else if (req == REQ_ENABLE_OP ||
								(!FIELDBUS_MODE_I && en_level))
								state_d = ST_OP_ENABLED;                 // R02
						// Disable operation drops to 5, shutdown to 4
						ST_OP_ENABLED:
							if (req == REQ_SWITCH_ON)
								state_d = ST_SWITCHED_ON;                // R10
							else if (req == REQ_SHUTDOWN)
								state_d = ST_READY;                      // R02
						default:
							state_d = state_q;
					endcase
				end
			end
		endcase
	end

	// A mode is idle when none runs or the drive has come to rest
	assign mode_idle = !run_q || STANDSTILL_I;                           // R17

	// Mode activation is separate from state changes
	// After a fault no mode runs, so the same or another mode may start
	// as soon as state 6 is reached again
	always_comb begin
		mode_d   = mode_q;
		run_d    = run_q;
		resume_d = resume_q;
		if (state_q != ST_OP_ENABLED) begin
			// Leaving state 6 discontinues the mode; a fault lets it resume later
			if (run_q && (state_q == ST_FAULT_REACTION || state_q == ST_FAULT))
				resume_d = 1'b1;                                         // R18
			run_d = 1'b0;                                                // R20
		end else if (INIT_DONE_I && opsel_q != 8'h00) begin              // R14
			if (!run_q || (opsel_q != mode_q && mode_idle)) begin        // R16
				mode_d   = opsel_q;                                      // R15
				run_d    = 1'b1;
				resume_d = 1'b0;                                         // R18
			end
		end
	end

	// Status word: state pattern on bits 0-3, 5, 6 plus flags
	// Don't-care bit 5 in states 2, 3, 8 and 9 is shown as zero
	// The word is registered, so it trails the state by one cycle
	always_comb begin
		word_d = 16'h0000;
		case (state_q)                                                   // R19
			ST_NOT_READY:      word_d[6:0] = 7'h00;
			ST_SW_ON_DISABLED: word_d[6:0] = 7'h40;
			ST_READY:          word_d[6:0] = 7'h21;
			ST_SWITCHED_ON:    word_d[6:0] = 7'h23;
			ST_OP_ENABLED:     word_d[6:0] = 7'h27;
			ST_QUICK_STOP:     word_d[6:0] = 7'h07;
			ST_FAULT_REACTION: word_d[6:0] = 7'h0f;
			ST_FAULT:          word_d[6:0] = 7'h08;
			default:           word_d[6:0] = 7'h00;
		endcase
		word_d[`STW_VOLTAGE] = VOLTAGE_OK_I;
		word_d[`STW_HALT]    = cmd_q[`CMD_HALT] & run_q;                 // R12
		word_d[`STW_REMOTE]  = FIELDBUS_MODE_I;
		word_d[`STW_TARGET]  = TARGET_REACHED_I & STANDSTILL_I & run_q;
		word_d[`STW_ERR]     = state_q == ST_FAULT || state_q == ST_FAULT_REACTION;
		word_d[`STW_END]     = mode_idle;                                // R17
	end

	// Registers
	// Reset leaves state 2 with an empty command word and no mode
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_q  <= ST_NOT_READY;                                    // R21
			cmd_q    <= `CMD_WORD_RESET;
			opsel_q  <= `OPMODE_RESET;
			mode_q   <= 8'h00;
			run_q    <= 1'b0;
			resume_q <= 1'b0;
			fc_bit_q <= 1'b0;
			word_q   <= 16'h0000;
			rdata_q  <= 16'h0000;
		end else begin
			state_q  <= state_d;
			cmd_q    <= cmd_d;
			opsel_q  <= opsel_d;
			mode_q   <= mode_d;
			run_q    <= run_d;
			resume_q <= resume_d;
			fc_bit_q <= fc_bit_d;
			word_q   <= word_d;
			rdata_q  <= rdata_d;
		end
	end

	// Outputs; bits 4-6 reach the mode only in fieldbus mode
	// Halt and mode bits are combinational from the command register
	assign PAR_RDATA_O        = rdata_q;
	assign ACTIVE_MODE_O      = mode_q;
	assign MODE_RUN_O         = run_q;
	assign MODE_BITS_O        = FIELDBUS_MODE_I ? cmd_q[`CMD_MODE_HI:`CMD_MODE_LO] : 3'h0; // R11
	assign HALT_O             = FIELDBUS_MODE_I & cmd_q[`CMD_HALT];      // R12
	assign POWER_ON_O         = state_q == ST_OP_ENABLED || state_q == ST_QUICK_STOP;
	assign DRIVE_STATE_WORD_O = word_q;

endmodule : drive_state_command_decoder

`default_nettype wire

// ===== drive_state_monitor.sv
// Checker for the ports of the drive state command decoder.
// Assumes binding to the top module; status word lags state by one cycle.
`timescale 1ns/1ps
`default_nettype none

module drive_state_monitor (
	// Clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_I,
	// Watched inputs
	input wire logic        FIELDBUS_MODE_I,
	input wire logic        INIT_DONE_I,
	input wire logic        FAULT_I,
	input wire logic        STANDSTILL_I,
	input wire logic        PAR_WR_I,
	input wire logic [15:0] PAR_ADDR_I,
	input wire logic [15:0] PAR_WDATA_I,
	// Watched outputs
	input wire logic [7:0]  ACTIVE_MODE_O,
	input wire logic        MODE_RUN_O,
	input wire logic [2:0]  MODE_BITS_O,
	input wire logic        HALT_O,
	input wire logic        POWER_ON_O,
	input wire logic [15:0] DRIVE_STATE_WORD_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// Masked state pattern and a command word write
	logic [15:0] sw;
	logic        wr_cmd;
	assign sw = DRIVE_STATE_WORD_O & 16'h006f;
	assign wr_cmd = PAR_WR_I && PAR_ADDR_I == 16'h1b02 && FIELDBUS_MODE_I;

	local_ctl_a: assert property (!FIELDBUS_MODE_I |-> MODE_BITS_O == 3'h0 && !HALT_O)
		else $error("mode bits or halt driven in local mode");
	halt_now_a: assert property (wr_cmd && PAR_WDATA_I[8] ##1 FIELDBUS_MODE_I |-> HALT_O)
		else $error("halt not raised after the write");
	run_in_op_a: assert property ($rose(MODE_RUN_O) |-> sw == 16'h0027)
		else $error("mode started outside operation enabled");
	run_ready_a: assert property ($rose(MODE_RUN_O) |-> $past(INIT_DONE_I))
		else $error("mode started while not initialised");
	mode_switch_a: assert property ($changed(ACTIVE_MODE_O)
		&& MODE_RUN_O && $past(MODE_RUN_O) |-> $past(STANDSTILL_I))
		else $error("mode switched while moving");
	power_state_a: assert property (POWER_ON_O |=> (DRIVE_STATE_WORD_O & 16'h000f) == 16'h0007)
		else $error("power on without state 6 or 7 shown");
	volt_off_a: assert property (wr_cmd && !PAR_WDATA_I[1] && INIT_DONE_I && !DRIVE_STATE_WORD_O[3]
		|-> ##[2:4] (DRIVE_STATE_WORD_O & 16'h004f) == 16'h0040)
		else $error("voltage off did not reach state 3");
	fault_first_a: assert property ((FAULT_I && INIT_DONE_I) [*4] |-> DRIVE_STATE_WORD_O[3])
		else $error("fault not shown in status");

	// Main scenarios reached
	cover property ($rose(MODE_RUN_O));
	cover property ($rose(DRIVE_STATE_WORD_O[3]));
	cover property (!FIELDBUS_MODE_I && POWER_ON_O);
endmodule : drive_state_monitor

bind drive_state_command_decoder drive_state_monitor i_mon (.CLK_I(CLK_I), .RST_I(RST_I),
	.FIELDBUS_MODE_I(FIELDBUS_MODE_I), .INIT_DONE_I(INIT_DONE_I), .FAULT_I(FAULT_I),
	.STANDSTILL_I(STANDSTILL_I), .PAR_WR_I(PAR_WR_I), .PAR_ADDR_I(PAR_ADDR_I),
	.PAR_WDATA_I(PAR_WDATA_I), .ACTIVE_MODE_O(ACTIVE_MODE_O), .MODE_RUN_O(MODE_RUN_O),
	.MODE_BITS_O(MODE_BITS_O), .HALT_O(HALT_O), .POWER_ON_O(POWER_ON_O),
	.DRIVE_STATE_WORD_O(DRIVE_STATE_WORD_O));
`default_nettype wire

// ===== fieldbus_master_model.sv
// Fieldbus master model for the parameter port.
// Assumes writes are taken on the rising edge with the strobe high.
`timescale 1ns/1ps
`default_nettype none
`include "drive_state_regs.svh"

module fieldbus_master_model (
	// Clock
	input  wire logic        clk_i,
	// Parameter port
	output logic             wr_o,
	output logic      [15:0] addr_o,
	output logic      [15:0] wdata_o,
	input  wire logic [15:0] rdata_i
);
	initial begin
		wr_o = 1'b0;
		addr_o = 16'h0000;
		wdata_o = 16'h0000;
	end
	// One-cycle write; reserved command bits always go out as zero
	task automatic put(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i) #1;
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = (a == `CMD_WORD_ADDR) ? (d & ~`CMD_RSVD_MASK) : d;
		@(posedge clk_i) #1;
		wr_o = 1'b0;
		wdata_o = ~wdata_o; // Released data must not look valid
	endtask : put
	// Read data answers one cycle after the address
	task automatic get(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_i) #1;
		addr_o = a;
		@(posedge clk_i) #1;
		d = rdata_i;
	endtask : get
endmodule : fieldbus_master_model
`default_nettype wire

// ===== drive_state_command_decoder_test.sv
// Self-checking bench for the drive state command decoder.
// Assumes the master model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "drive_state_regs.svh"

module drive_state_command_decoder_test;
	logic        clk = 1'b0, rst = 1'b1, fb = 1'b1, en = 1'b0, fclr = 1'b0;
	logic        init = 1'b1, volt = 1'b1, flt = 1'b0, frd = 1'b0, still = 1'b0, tgt = 1'b0;
	logic        wr, run, halt, pwr;
	logic [2:0]  mbits;
	logic [7:0]  mode;
	logic [15:0] addr, wdata, rdata, sw, rd;
	logic [15:0] tbl [11][4];
	int          fail_count = 0, n_tests = 0, cyc = 0;

	always #5 clk = ~clk;

	drive_state_command_decoder i_dut (.CLK_I(clk), .RST_I(rst), .FIELDBUS_MODE_I(fb),
		.ENABLE_PIN_I(en), .FAULT_CLEAR_PIN_I(fclr), .INIT_DONE_I(init), .VOLTAGE_OK_I(volt),
		.FAULT_I(flt), .FAULT_REACTION_DONE_I(frd), .STANDSTILL_I(still),
		.TARGET_REACHED_I(tgt), .PAR_WR_I(wr), .PAR_ADDR_I(addr), .PAR_WDATA_I(wdata),
		.PAR_RDATA_O(rdata), .ACTIVE_MODE_O(mode), .MODE_RUN_O(run), .MODE_BITS_O(mbits),
		.HALT_O(halt), .POWER_ON_O(pwr), .DRIVE_STATE_WORD_O(sw));
	fieldbus_master_model m (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
		.rdata_i(rdata));

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	initial begin
		// Command, state mask, state pattern, {halt, mode bits}
		tbl = '{'{16'h0006, 16'h006f, 16'h0021, 16'h0000},
			'{16'h0007, 16'h006f, 16'h0023, 16'h0000},
			'{16'h000f, 16'h006f, 16'h0027, 16'h0000},
			'{16'h0007, 16'h006f, 16'h0023, 16'h0000},
			'{16'h007f, 16'h006f, 16'h0027, 16'h0007},
			'{16'h010f, 16'h006f, 16'h0027, 16'h0008},
			'{16'h008f, 16'h006f, 16'h0027, 16'h0000},
			'{16'h000b, 16'h006f, 16'h0007, 16'h0000},
			'{16'h000d, 16'h004f, 16'h0040, 16'h0000},
			'{16'h000e, 16'h006f, 16'h0021, 16'h0000},
			'{16'h0003, 16'h004f, 16'h0040, 16'h0000}};
		tick(2);
		rst = 1'b0;
		chk("status after reset", 16'h0000, sw);
		m.get(`CMD_WORD_ADDR, rd);
		chk("command reset", 16'h0000, rd);
		$display("Test reset done");
		foreach (tbl[i]) begin
			m.put(`CMD_WORD_ADDR, tbl[i][0]);
			tick(5);
			chk("state bits", tbl[i][2], sw & tbl[i][1]);
			chk("halt and mode bits", tbl[i][3], {12'h000, halt, mbits});
		end
		m.get(`CMD_WORD_ADDR, rd);
		chk("command readback", 16'h0003, rd);
		m.get(`STATE_WORD_ADDR, rd);
		chk("status readback", 16'h0040, rd & 16'h004f);
		m.put(16'h1b05, 16'h1234);
		m.get(16'h1b05, rd);
		chk("unmapped read", 16'h0000, rd);
		$display("Test fieldbus table done");
		// A second mode may only take over at standstill
		m.put(`CMD_WORD_ADDR, 16'h0006);
		m.put(`CMD_WORD_ADDR, 16'h000f);
		tick(5);
		m.put(`OPMODE_ADDR, 16'h0001);
		tick(3);
		chk("mode start", 16'h0101, {7'h00, run, mode});
		m.put(`OPMODE_ADDR, 16'h00fd);
		tick(3);
		chk("mode held while moving", 16'h0101, {7'h00, run, mode});
		still = 1'b1;
		tick(3);
		chk("mode switch at standstill", 16'h01fd, {7'h00, run, mode});
		tgt = 1'b1;
		m.get(`OPMODE_ADDR, rd);
		chk("mode readback", 16'hfffd, rd);
		chk("target reached", 16'h0400, sw & 16'h0400);
		m.put(`CMD_WORD_ADDR, 16'h0007);
		tick(4);
		chk("mode stop off state 6", 16'h0000, {15'h0000, run});
		// Quick stop at standstill falls through state 7 to state 3
		m.put(`CMD_WORD_ADDR, 16'h000f);
		m.put(`CMD_WORD_ADDR, 16'h000b);
		tick(4);
		chk("quick stop to rest", 16'h0040, sw & 16'h004f);
		$display("Test modes done");
		// Fault, reaction, then clear by a bit 7 rising edge
		flt = 1'b1;
		tick(4);
		chk("fault reaction", 16'h000f, sw & 16'h004f);
		frd = 1'b1;
		tick(4);
		chk("fault state", 16'h0008, sw & 16'h004f);
		flt = 1'b0;
		frd = 1'b0;
		m.put(`CMD_WORD_ADDR, 16'h0080);
		tick(5);
		chk("fault reset", 16'h0040, sw & 16'h004f);
		$display("Test fault done");
		// Local control: the command word has no say
		fb = 1'b0;
		m.put(`CMD_WORD_ADDR, 16'h000f);
		tick(5);
		chk("local ignores command", 16'h0040, sw & 16'h004f);
		en = 1'b1;
		tick(10);
		chk("local enable rise", 16'h0027, sw & 16'h006f);
		chk("power on", 16'h0001, {15'h0000, pwr});
		en = 1'b0;
		tick(10);
		chk("local enable fall", 16'h0021, sw & 16'h006f);
		flt = 1'b1;
		frd = 1'b1;
		en = 1'b1;
		tick(5);
		flt = 1'b0;
		frd = 1'b0;
		fclr = 1'b1;
		tick(12);
		chk("local fault clear", 16'h0027, sw & 16'h006f);
		$display("Test local done");
		give_verdict();
	end
endmodule : drive_state_command_decoder_test
`default_nettype wire
